// File: core/ascl_serial_load.sv
// Purpose: Serial configuration load and result shift-out for a four-channel converter.
// Assumes: Serial clock and frame select come from the host and are slower than clock / 4.
// Notes: Serial pins are sampled and edges found in the system clock domain.
// What this block does
// - Holds a 12-bit configuration register, written serially, never readable.
// - Captures each configuration bit on a falling serial clock edge.
// - Configuration shifts in while previous result shifts out, same clocks.
// - Word received in a frame governs conversions from the next one on, not the current one.
// - Only the first twelve falling edges after frame start load configuration.
// - Configuration word travels most significant bit first.
// - Sampling stage returns to tracking at end of each conversion.
// - First bit one writes all twelve bits, that bit included; zero keeps register.
// - Output frame is two zeros, two channel bits, twelve result bits.
// - Each output bit after the first changes on a falling serial clock edge; frame start presents the first zero.
// - Frame select falling edge starts conversion and begins the frame.
`timescale 1ns/1ps
`default_nettype none
`include "ascl_cfg.svh"
module ascl_serial_load
  import ascl_pkg::*;
#(
  parameter int CFG_WIDTH = `ASCL_CFG_WIDTH,
  parameter int RESULT_WIDTH = `ASCL_RESULT_WIDTH,
  parameter int FRAME_CLOCKS = `ASCL_FRAME_CLOCKS
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic serial_clock,
  input wire logic frame_select_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_enable_n,
  input wire logic [RESULT_WIDTH-1:0] conversion_result,
  input wire logic result_valid,
  output logic conversion_start,
  output logic track,
  output logic [CFG_WIDTH-1:0] active_config,
  output logic [1:0] channel_select
);

  logic [2:0] sclk_sync;
  logic [2:0] cs_sync;
  logic din_meta;
  logic din_sync;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;

  ascl_state_t state;
  ascl_state_t next_state;
  logic [4:0] edge_count;
  logic [4:0] next_edge_count;
  logic [CFG_WIDTH-1:0] shift_in;
  logic [CFG_WIDTH-1:0] next_shift_in;
  logic [CFG_WIDTH-1:0] config_word;
  logic [CFG_WIDTH-1:0] next_config_word;
  logic [CFG_WIDTH-1:0] pending_config;
  logic [CFG_WIDTH-1:0] next_pending_config;
  logic pending_write;
  logic next_pending_write;
  logic [15:0] shift_out;
  logic [15:0] next_shift_out;
  logic [RESULT_WIDTH-1:0] held_result;
  logic [RESULT_WIDTH-1:0] next_held_result;
  logic [1:0] held_channel;
  logic [1:0] next_held_channel;
  logic [1:0] conv_channel;
  logic [1:0] next_conv_channel;
  logic next_serial_out;
  logic next_enable_n;
  logic next_start;
  logic next_track;

  // Two-stage synchronisers; edge detection reads only the second stage and later.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sclk_sync <= 3'h7;
      cs_sync <= 3'h7;
      din_meta <= 1'b0;
      din_sync <= 1'b0;
    end else begin
      sclk_sync <= {sclk_sync[1:0], serial_clock};
      cs_sync <= {cs_sync[1:0], frame_select_n};
      din_meta <= serial_in;
      din_sync <= din_meta;
    end
  end

  // Reports a step from high to low between two successive synchronised samples.
  function automatic logic ascl_fell(input logic older, input logic newer);
    return older & ~newer;
  endfunction

  // Reports a step from low to high between two successive synchronised samples.
  function automatic logic ascl_rose(input logic older, input logic newer);
    return ~older & newer;
  endfunction

  assign sclk_fall = ascl_fell(sclk_sync[2], sclk_sync[1]);
  assign cs_fall = ascl_fell(cs_sync[2], cs_sync[1]);
  assign cs_rise = ascl_rose(cs_sync[2], cs_sync[1]);

  // Next values for the frame sequencer, the configuration path and the output pin.
  always_comb begin
    next_state = state;
    next_edge_count = edge_count;
    next_shift_in = shift_in;
    next_config_word = config_word;
    next_pending_config = pending_config;
    next_pending_write = pending_write;
    next_shift_out = shift_out;
    next_held_result = held_result;
    next_held_channel = held_channel;
    next_conv_channel = conv_channel;
    next_serial_out = serial_out;
    next_enable_n = serial_out_enable_n;
    next_start = 1'b0;
    next_track = track;
    // End of conversion keeps the result for the next frame and loads any waiting word.
    if (result_valid) begin
      next_held_result = conversion_result;
      next_held_channel = conv_channel;
      next_track = 1'b1;
      if (pending_write) begin
        next_config_word = pending_config;
        next_pending_write = 1'b0;
      end
    end
    case (state)
      ASCL_IDLE: begin
        next_enable_n = 1'b1;
        // Frame start samples the input, picks the channel and presents the first leading zero.
        if (cs_fall) begin
          next_state = ASCL_SHIFT;
          next_edge_count = 5'h00;
          next_start = 1'b1;
          next_track = 1'b0;
          next_conv_channel = config_word[`ASCL_CHAN_HIGH_BIT:`ASCL_CHAN_LOW_BIT];
          next_shift_out = {2'b00, held_channel, held_result};
          next_serial_out = 1'b0;
          next_enable_n = 1'b0;
        end
      end
      ASCL_SHIFT: begin
        if (cs_rise) begin
          next_state = ASCL_IDLE;
          next_enable_n = 1'b1;
        end else if (sclk_fall) begin
          next_edge_count = edge_count + 5'h01;
          next_shift_out = {shift_out[14:0], 1'b0};
          next_serial_out = shift_out[14];
          // Edges after the twelfth leave the received word alone.
          if (edge_count < 5'(CFG_WIDTH)) begin
            next_shift_in = {shift_in[CFG_WIDTH-2:0], din_sync};
          end
          if (edge_count == 5'(CFG_WIDTH - 1)) begin
            // The first bit received lands in the top position.
            if (shift_in[CFG_WIDTH-2]) begin
              next_pending_config = {shift_in[CFG_WIDTH-2:0], din_sync};
              next_pending_write = 1'b1;
            end
          end
          if (edge_count == 5'(FRAME_CLOCKS - 1)) begin
            next_state = ASCL_DONE;
          end
        end
      end
      ASCL_DONE: begin
        if (cs_rise) begin
          next_state = ASCL_IDLE;
          next_enable_n = 1'b1;
        end
      end
      default: begin
        next_state = ASCL_IDLE;
      end
    endcase
  end

  // Registers only; reset leaves the output released and the sampling stage tracking.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= ASCL_IDLE;
      edge_count <= 5'h00;
      shift_in <= {CFG_WIDTH{1'b0}};
      config_word <= CFG_WIDTH'(`ASCL_CFG_RESET);
      pending_config <= CFG_WIDTH'(`ASCL_CFG_RESET);
      pending_write <= 1'b0;
      shift_out <= 16'h0000;
      held_result <= {RESULT_WIDTH{1'b0}};
      held_channel <= 2'h0;
      conv_channel <= 2'h0;
      serial_out <= 1'b0;
      serial_out_enable_n <= 1'b1;
      conversion_start <= 1'b0;
      track <= 1'b1;
    end else begin
      state <= next_state;
      edge_count <= next_edge_count;
      shift_in <= next_shift_in;
      config_word <= next_config_word;
      pending_config <= next_pending_config;
      pending_write <= next_pending_write;
      shift_out <= next_shift_out;
      held_result <= next_held_result;
      held_channel <= next_held_channel;
      conv_channel <= next_conv_channel;
      serial_out <= next_serial_out;
      serial_out_enable_n <= next_enable_n;
      conversion_start <= next_start;
      track <= next_track;
    end
  end

  // The configuration register reaches only the converter core, never the serial output.
  assign active_config = config_word;
  assign channel_select = conv_channel;

endmodule
`default_nettype wire

// File: shared/ascl_cfg.svh
// Purpose: Constants for the converter serial front end.
// Assumes: One system clock; serial pins sampled into it.
// Notes: Bit positions refer to the 12-bit configuration word.
`ifndef ASCL_CFG_SVH
`define ASCL_CFG_SVH
`define ASCL_CFG_WIDTH 12
`define ASCL_RESULT_WIDTH 12
`define ASCL_FRAME_CLOCKS 16
`define ASCL_WRITE_BIT 11
`define ASCL_CHAN_HIGH_BIT 7
`define ASCL_CHAN_LOW_BIT 6
`define ASCL_CFG_RESET 12'h000
`endif

// File: shared/ascl_pkg.sv
// Purpose: Types for the converter serial front end.
// Assumes: Constants come from the configuration header.
// Notes: None.
package ascl_pkg;
  typedef enum logic [1:0] {
    ASCL_IDLE = 2'b00,
    ASCL_SHIFT = 2'b01,
    ASCL_DONE = 2'b10
  } ascl_state_t;
endpackage

// File: verification/adc_serial_control_load_tb_top.sv
// Purpose: Self-checking bench for the serial load block.
// Assumes: Bench plays the converter core.
// Notes: None.
`timescale 1ns/1ps
`default_nettype none
module adc_serial_control_load_tb_top;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic result_valid = 1'h0;
  logic [11:0] conversion_result = 12'h000;
  wire logic serial_clock, frame_select_n, serial_in, serial_out, serial_out_enable_n, conversion_start, track;
  wire logic [11:0] active_config;
  wire logic [1:0] channel_select;
  int n_fail = 0;
  int samples_checked = 0;
  logic [15:0] dout;
  logic [11:0] exp_cfg = 12'h000;
  logic [11:0] prev_res;
  logic [1:0] prev_ch;
  logic [35:0] rows [4] = '{36'h8C0A5C8C0, 36'h0403F18C0, 36'h8800F0880, 36'hFFF7E3FFF};
  always #2 clock = ~clock;
  ascl_serial_load ascl_serial_load_inst (.clock, .rst, .serial_clock, .frame_select_n, .serial_in, .serial_out,
    .serial_out_enable_n, .conversion_result, .result_valid, .conversion_start, .track, .active_config, .channel_select);
  ascl_host_model ascl_host_model_inst (.clock, .serial_out, .serial_clock, .frame_select_n, .serial_in);
  task automatic check(input logic [23:0] seen, input logic [23:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic summarize;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic convert(input logic [11:0] res);
    @(negedge clock) conversion_result = res;
    result_valid = 1'h1;
    @(negedge clock) result_valid = 1'h0;
    repeat (4) @(negedge clock);
  endtask
  initial begin
    repeat (12) @(negedge clock);
    rst = 1'h0;
    @(negedge clock);
    check({track, serial_out_enable_n, conversion_start, serial_out, channel_select, active_config},
      24'h030000);
    $display("reset test done");
    foreach (rows[k]) begin
      ascl_host_model_inst.frame({rows[k][35:24], 4'hA}, 16, dout);
      if (k > 0) check(dout, {2'h0, prev_ch, prev_res});
      check({channel_select, track}, {exp_cfg[7:6], 1'h0});
      prev_ch = exp_cfg[7:6];
      prev_res = rows[k][23:12];
      convert(prev_res);
      exp_cfg = rows[k][11:0];
      check({active_config, track}, {exp_cfg, 1'h1});
      $display("row %0d done", k);
    end
    ascl_host_model_inst.frame({12'h840, 4'hA}, 10, dout);
    convert(12'h555);
    check(active_config, exp_cfg);
    ascl_host_model_inst.frame(16'h0000, 16, dout);
    check(dout, {2'h0, exp_cfg[7:6], 12'h555});
    $display("abort test done");
    @(negedge clock) rst = 1'h1;
    repeat (3) @(negedge clock);
    rst = 1'h0;
    @(negedge clock);
    check({track, serial_out_enable_n, conversion_start, serial_out, channel_select, active_config},
      24'h030000);
    $display("mid reset test done");
    summarize();
  end
  initial begin
    repeat (6000) @(posedge clock);
    n_fail++;
    summarize();
  end
endmodule
bind ascl_serial_load ascl_serial_load_assertions #(.CFG_WIDTH(CFG_WIDTH)) ascl_serial_load_assertions_inst (.clock,
  .rst, .serial_clock, .frame_select_n, .serial_out, .serial_out_enable_n, .result_valid, .conversion_start, .track,
  .active_config, .channel_select);
`default_nettype wire

// File: verification/ascl_host_model.sv
// Purpose: Host serial port model.
// Assumes: Driven at falling system clock edges.
// Notes: Serial clock idles high between frames.
`timescale 1ns/1ps
`default_nettype none
module ascl_host_model (
  input wire logic clock,
  input wire logic serial_out,
  output logic serial_clock,
  output logic frame_select_n,
  output logic serial_in
);
  initial begin
    serial_clock = 1'h1;
    frame_select_n = 1'h1;
    serial_in = 1'h0;
  end
  task automatic frame(input logic [15:0] din, input int falls, output logic [15:0] dout);
    dout = 16'h0000;
    @(negedge clock) frame_select_n = 1'h0;
    repeat (8) @(negedge clock);
    for (int i = 15; i > 15 - falls; i--) begin
      serial_in = din[i];
      repeat (4) @(negedge clock);
      dout[i] = serial_out;
      serial_clock = 1'h0;
      repeat (8) @(negedge clock);
      serial_clock = 1'h1;
      repeat (4) @(negedge clock);
    end
    frame_select_n = 1'h1;
    serial_in = ~serial_in;
    repeat (8) @(negedge clock);
  endtask
endmodule
`default_nettype wire

// File: verification/ascl_serial_load_assertions.sv
// Purpose: Port checks for the serial load block.
// Assumes: Each serial clock phase lasts several system clocks.
// Notes: Bound from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module ascl_serial_load_assertions #(parameter int CFG_WIDTH = 12) (
  input wire logic clock,
  input wire logic rst,
  input wire logic serial_clock,
  input wire logic frame_select_n,
  input wire logic serial_out,
  input wire logic serial_out_enable_n,
  input wire logic result_valid,
  input wire logic conversion_start,
  input wire logic track,
  input wire logic [CFG_WIDTH-1:0] active_config,
  input wire logic [1:0] channel_select
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  AST_START_PULSE: assert property (conversion_start |=> !conversion_start) else $error("long start");
  AST_START_SEEN: assert property ($fell(frame_select_n) |-> ##[2:6] conversion_start) else $error("no start");
  AST_FIRST_ZERO: assert property (conversion_start |-> !serial_out_enable_n && !serial_out && !track)
    else $error("bad frame start");
  AST_TRACK_BACK: assert property (result_valid |=> track) else $error("no track");
  AST_CFG_AT_END: assert property ($changed(active_config) |-> $past(result_valid) || $past(result_valid, 2))
    else $error("config moved early");
  AST_CHAN_AT_START: assert property ($changed(channel_select) |-> conversion_start || $past(conversion_start))
    else $error("channel moved");
  AST_IDLE_OFF: assert property (frame_select_n [*6] |-> serial_out_enable_n) else $error("still driving");
  AST_OUT_ON_FALL: assert property ($changed(serial_out) && !serial_out_enable_n |-> conversion_start || !serial_clock)
    else $error("output off fall");
  cover property (conversion_start);
  cover property (result_valid ##1 track);
  cover property ($changed(active_config));
endmodule
`default_nettype wire
